//--- cpu_regs_params.svh
// Offsets, field positions and reset values of the program register file
`ifndef CPU_REGS_PARAMS_SVH
`define CPU_REGS_PARAMS_SVH

// ==========================================
// Register offsets (byte addresses, word aligned)
`define RF_OFS_ACC 8'h00
`define RF_OFS_PAGE 8'h04
`define RF_OFS_IDX1 8'h08
`define RF_OFS_IDX2 8'h0C
`define RF_OFS_USP 8'h10
`define RF_OFS_HSP 8'h14
`define RF_OFS_PC 8'h18
`define RF_OFS_CC 8'h1C

// ==========================================
// Condition code bit positions
`define CC_CARRY 0
`define CC_OVFL 1
`define CC_ZERO 2
`define CC_NEG 3
`define CC_NMASK 4
`define CC_HALF 5
`define CC_FMASK 6
`define CC_ENTIRE 7

// ==========================================
// Reset values
`define RF_RST_PAGE 8'h00
`define RF_RST_CC 8'h50
`define RF_RST_WORD 16'h0000
`define RF_RST_BYTE 8'h00

`endif

//--- cpu_regs_pkg.sv
// Types shared by the program register file and its users
package cpu_regs_pkg;

  typedef enum logic [6:0] {
    ALU_ADD = 7'h01,
    ALU_ADC = 7'h02,
    ALU_SUB = 7'h04,
    ALU_SBC = 7'h08,
    ALU_CMP = 7'h10,
    ALU_NEG = 7'h20,
    ALU_LD = 7'h40
  } alu_kind_t;

  typedef enum logic [6:0] {
    ENT_NMI = 7'h01,
    ENT_FAST = 7'h02,
    ENT_NORM = 7'h04,
    ENT_RESET = 7'h08,
    ENT_TRAP1 = 7'h10,
    ENT_TRAP2 = 7'h20,
    ENT_TRAP3 = 7'h40
  } entry_kind_t;

  typedef enum logic [4:0] {
    BASE_IDX1 = 5'h01,
    BASE_IDX2 = 5'h02,
    BASE_USP = 5'h04,
    BASE_HSP = 5'h08,
    BASE_PC = 5'h10
  } base_sel_t;

endpackage

//--- cpu_program_registers.sv
// Programmer-visible registers and condition-code logic of the 8-bit core
`timescale 1ns/1ns
`include "cpu_regs_params.svh"

module cpu_program_registers (
  input wire logic clk_sys_i, // 100 MHz clock
  input wire logic rstn_i, // Synchronous reset, active low
  input wire logic ce_i, // Clock enable, freezes all state
  input wire logic hsel_i, // AHB select
  input wire logic [31:0] haddr_i, // AHB address
  input wire logic [1:0] htrans_i, // AHB transfer type
  input wire logic hwrite_i, // AHB write
  input wire logic [2:0] hsize_i, // AHB size, words only
  input wire logic [31:0] hwdata_i, // AHB write data
  input wire logic hready_i, // AHB bus ready
  output logic [31:0] hrdata_o, // AHB read data
  output logic hreadyout_o, // AHB slave ready
  output logic hresp_o, // AHB response, always OKAY
  input wire logic alu_go_i, // Accumulator operation strobe
  input wire cpu_regs_pkg::alu_kind_t alu_kind_i, // Operation
  input wire logic alu_wide_i, // Use 16-bit pair
  input wire logic alu_dst_low_i, // 8-bit target is low accumulator
  input wire logic [15:0] alu_opnd_i, // Second operand
  input wire logic dir_go_i, // Direct-mode address request
  input wire logic [7:0] dir_low_i, // Direct-mode low address byte
  input wire logic idx_go_i, // Indexed address request
  input wire cpu_regs_pkg::base_sel_t idx_base_i, // Base register
  input wire logic [15:0] idx_ofs_i, // Constant or register offset
  input wire logic [2:0] idx_step_i, // Signed base step, -4..+3
  input wire logic stk_go_i, // One-byte stack operation
  input wire logic stk_user_i, // 1: user stack, 0: hardware stack
  input wire logic stk_push_i, // 1: push, 0: pull
  input wire logic ent_go_i, // Exception entry strobe
  input wire cpu_regs_pkg::entry_kind_t ent_kind_i, // Exception kind
  input wire logic ret_go_i, // Interrupt return strobe
  input wire logic [7:0] ret_cc_i, // Stacked condition codes
  input wire logic pc_load_i, // Load program counter
  input wire logic [15:0] pc_value_i, // New program counter
  input wire logic pc_inc_i, // Advance program counter by one
  output logic [15:0] addr_o, // Effective address
  output logic [15:0] acc_pair_o, // Accumulator pair
  output logic [15:0] prog_counter_o, // Program counter
  output logic [7:0] cond_codes_o, // Condition codes
  output logic ret_entire_o // Return unstacks full register set
);
  import cpu_regs_pkg::*;

  default clocking dflt_cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  // ==========================================
  // Storage
  logic [7:0] acc_high_q;
  logic [7:0] acc_low_q;
  logic [7:0] page_base_q;
  logic [15:0] ptr_q [4];
  logic [15:0] prog_counter_q;
  logic [7:0] cc_q;
  logic [7:0] wa_q;
  logic wr_ph_q;

  // Maps a byte address to one-hot register select
  function automatic logic [7:0] reg_hit(input logic [7:0] a);
    reg_hit = {a == `RF_OFS_CC, a == `RF_OFS_PC, a == `RF_OFS_HSP,
      a == `RF_OFS_USP, a == `RF_OFS_IDX2, a == `RF_OFS_IDX1,
      a == `RF_OFS_PAGE, a == `RF_OFS_ACC};
  endfunction

  // ==========================================
  // AHB-Lite slave, zero wait states
  logic addr_ph;
  logic [7:0] wsel;
  logic [7:0] rsel;
  logic [31:0] rd_d;
  assign addr_ph = hsel_i && htrans_i[1] && hready_i;
  assign wsel = wr_ph_q ? reg_hit(wa_q) : 8'h00;
  assign rsel = reg_hit(haddr_i[7:0]);

  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (rsel[0]) rd_d[15:0] = {acc_high_q, acc_low_q};
    if (rsel[1]) rd_d[7:0] = page_base_q;
    if (rsel[2]) rd_d[15:0] = ptr_q[0];
    if (rsel[3]) rd_d[15:0] = ptr_q[1];
    if (rsel[4]) rd_d[15:0] = ptr_q[2];
    if (rsel[5]) rd_d[15:0] = ptr_q[3];
    if (rsel[6]) rd_d[15:0] = prog_counter_q;
    if (rsel[7]) rd_d[7:0] = cc_q;
    // A write still in its data phase lands only at the coming edge; pass
    // its data on so that a read straight behind it sees the new value
    if (wr_ph_q && wa_q == haddr_i[7:0])
    begin
      if (rsel[1] || rsel[7])
        rd_d = {24'h00_0000, hwdata_i[7:0]};
      else if (rsel != 8'h00)
        rd_d = {16'h0000, hwdata_i[15:0]};
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      wr_ph_q <= 1'b0;
      wa_q <= 8'h00;
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
    else if (ce_i)
    begin
      wr_ph_q <= addr_ph && hwrite_i;
      wa_q <= haddr_i[7:0];
      // Read data is taken in the address phase, with the bypass above
      if (addr_ph && !hwrite_i)
        hrdata_o <= rd_d;
    end
  end

  // ==========================================
  // Adder shared by all accumulator operations except ALU_LD
  logic is_sub;
  logic cin;
  logic [15:0] a_op;
  logic [15:0] b_op;
  logic [16:0] sum17;
  logic [15:0] low15;
  logic [8:0] sum9;
  logic [7:0] low7;
  logic [4:0] nib;
  logic [15:0] res;
  logic c_top;
  logic c_below;
  logic [7:0] dst8;

  assign dst8 = alu_dst_low_i ? acc_low_q : acc_high_q;
  assign is_sub = alu_kind_i inside {ALU_SUB, ALU_SBC, ALU_CMP, ALU_NEG};

  always_comb
  begin
    a_op = alu_wide_i ? {acc_high_q, acc_low_q} : {8'h00, dst8};
    b_op = alu_opnd_i;
    if (alu_kind_i == ALU_NEG)
    begin
      b_op = a_op;
      a_op = 16'h0000;
    end
    if (is_sub) b_op = ~b_op;
    case (alu_kind_i)
      ALU_ADC: cin = cc_q[`CC_CARRY];
      ALU_SBC: cin = ~cc_q[`CC_CARRY];
      ALU_SUB, ALU_CMP, ALU_NEG: cin = 1'b1;
      default: cin = 1'b0;
    endcase
  end

  assign sum17 = {1'b0, a_op} + {1'b0, b_op} + {16'h0000, cin};
  assign low15 = {1'b0, a_op[14:0]} + {1'b0, b_op[14:0]} + {15'h0000, cin};
  assign sum9 = {1'b0, a_op[7:0]} + {1'b0, b_op[7:0]} + {8'h00, cin};
  assign low7 = {1'b0, a_op[6:0]} + {1'b0, b_op[6:0]} + {7'h00, cin};
  assign nib = {1'b0, a_op[3:0]} + {1'b0, b_op[3:0]} + {4'h0, cin};

  always_comb
  begin
    if (alu_kind_i == ALU_LD)
      res = alu_opnd_i;
    else
      res = sum17[15:0];
    if (!alu_wide_i) res[15:8] = 8'h00;
    c_top = alu_wide_i ? sum17[16] : sum9[8];
    c_below = alu_wide_i ? low15[15] : low7[7];
  end

  // ==========================================
  // Accumulators
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      acc_high_q <= `RF_RST_BYTE;
      acc_low_q <= `RF_RST_BYTE;
    end
    else if (ce_i)
    begin
      if (wsel[0])
        {acc_high_q, acc_low_q} <= hwdata_i[15:0];
      else if (alu_go_i && alu_kind_i != ALU_CMP)
      begin
        if (alu_wide_i)
          {acc_high_q, acc_low_q} <= res;
        else if (alu_dst_low_i)
          acc_low_q <= res[7:0];
        else
          acc_high_q <= res[7:0];
      end
    end
  end

  // ==========================================
  // Direct page base
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      page_base_q <= `RF_RST_PAGE;
    else if (ce_i && wsel[1])
      page_base_q <= hwdata_i[7:0];
  end

  // ==========================================
  // Pointer registers: index one, index two, user and hardware stack
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_ptr
      logic stk_hit;
      assign stk_hit = stk_go_i && (gi >= 2) && (stk_user_i == (gi == 2));
      always_ff @(posedge clk_sys_i)
      begin
        if (!rstn_i)
          ptr_q[gi] <= `RF_RST_WORD;
        else if (ce_i)
        begin
          if (wsel[2 + gi])
            ptr_q[gi] <= hwdata_i[15:0];
          else if (stk_hit)
            ptr_q[gi] <= stk_push_i ? ptr_q[gi] - 16'h0001
                                    : ptr_q[gi] + 16'h0001;
          else if (idx_go_i && idx_base_i[gi])
            ptr_q[gi] <= ptr_q[gi] + {{13{idx_step_i[2]}}, idx_step_i};
        end
      end
    end
  endgenerate

  // ==========================================
  // Program counter
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      prog_counter_q <= `RF_RST_WORD;
    else if (ce_i)
    begin
      if (wsel[6])
        prog_counter_q <= hwdata_i[15:0];
      else if (pc_load_i)
        prog_counter_q <= pc_value_i;
      else if (pc_inc_i)
        prog_counter_q <= prog_counter_q + 16'h0001;
    end
  end

  // ==========================================
  // Address output
  logic [15:0] base;
  logic [15:0] stepped;
  always_comb
  begin
    case (idx_base_i)
      BASE_IDX1: base = ptr_q[0];
      BASE_IDX2: base = ptr_q[1];
      BASE_USP: base = ptr_q[2];
      BASE_HSP: base = ptr_q[3];
      BASE_PC: base = prog_counter_q;
      default: base = 16'h0000;
    endcase
  end
  // A negative step is a pre-decrement and addresses the new value
  assign stepped = idx_step_i[2] ? base + {13'h1FFF, idx_step_i} : base;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      addr_o <= `RF_RST_WORD;
    else if (ce_i)
    begin
      if (dir_go_i)
        addr_o <= {page_base_q, dir_low_i};
      else if (stk_go_i)
        addr_o <= (stk_user_i ? ptr_q[2] : ptr_q[3])
                  - (stk_push_i ? 16'h0001 : 16'h0000);
      else if (idx_go_i)
        addr_o <= stepped + idx_ofs_i;
    end
  end

  // ==========================================
  // Condition codes
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      cc_q <= `RF_RST_CC;
      ret_entire_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wsel[7])
        cc_q <= hwdata_i[7:0];
      else if (ret_go_i)
      begin
        cc_q <= ret_cc_i;
        ret_entire_o <= ret_cc_i[`CC_ENTIRE];
      end
      else if (ent_go_i)
      begin
        cc_q[`CC_ENTIRE] <= (ent_kind_i != ENT_FAST);
        if (ent_kind_i inside {ENT_NMI, ENT_FAST, ENT_NORM, ENT_RESET,
                               ENT_TRAP1})
          cc_q[`CC_NMASK] <= 1'b1;
        if (ent_kind_i inside {ENT_NMI, ENT_FAST, ENT_RESET, ENT_TRAP1})
          cc_q[`CC_FMASK] <= 1'b1;
      end
      else if (alu_go_i)
      begin
        cc_q[`CC_ZERO] <= (res == 16'h0000);
        cc_q[`CC_NEG] <= alu_wide_i ? res[15] : res[7];
        if (alu_kind_i == ALU_LD)
          cc_q[`CC_OVFL] <= 1'b0;
        else
        begin
          cc_q[`CC_OVFL] <= c_top ^ c_below;
          cc_q[`CC_CARRY] <= is_sub ? ~c_top : c_top;
        end
        // half carry on byte adds only
        if (!alu_wide_i && alu_kind_i inside {ALU_ADD, ALU_ADC})
          cc_q[`CC_HALF] <= nib[4];
      end
    end
  end

  assign acc_pair_o = {acc_high_q, acc_low_q};
  assign prog_counter_o = prog_counter_q;
  assign cond_codes_o = cc_q;

  // ==========================================
  // Checks
  logic core_ok;
  assign core_ok = ce_i && !wr_ph_q;

  AST_PAIR_LOAD: assert property (
    core_ok && alu_go_i && alu_kind_i == ALU_LD && alu_wide_i
    |=> acc_high_q == $past(alu_opnd_i[15:8])
        && acc_low_q == $past(alu_opnd_i[7:0]))
    else $error("pair load order wrong");
  AST_DIRECT_PAGE: assert property (
    ce_i && dir_go_i |=> addr_o == {$past(page_base_q), $past(dir_low_i)})
    else $error("direct address wrong");
  // Reset is the trigger here, so the default disable is switched off
  AST_RESET_CLEAR: assert property (disable iff (1'b0)
    !rstn_i |=> page_base_q == 8'h00 && cc_q[`CC_NMASK] && cc_q[`CC_FMASK])
    else $error("reset state wrong");
  AST_PUSH_TOP: assert property (
    core_ok && stk_go_i && !stk_user_i && stk_push_i && !dir_go_i
    |=> ptr_q[3] == $past(ptr_q[3]) - 16'h0001 && addr_o == ptr_q[3])
    else $error("push does not address top");
  AST_USER_STILL: assert property (
    ce_i && !wsel[4] && !(stk_go_i && stk_user_i)
    && !(idx_go_i && idx_base_i == BASE_USP) |=> $stable(ptr_q[2]))
    else $error("user stack moved");
  AST_BORROW: assert property (
    core_ok && alu_go_i && !ret_go_i && !ent_go_i && alu_kind_i == ALU_SUB
    && !alu_wide_i
    |=> cc_q[`CC_CARRY] == ($past(dst8) < $past(alu_opnd_i[7:0])))
    else $error("borrow wrong");
  AST_ZERO_NEG: assert property (
    core_ok && alu_go_i && !ret_go_i && !ent_go_i && alu_kind_i == ALU_LD
    && !alu_wide_i && !alu_dst_low_i
    |=> cc_q[`CC_ZERO] == (acc_high_q == 8'h00)
        && cc_q[`CC_NEG] == acc_high_q[7])
    else $error("zero or negative flag wrong");
  AST_TRAP_MASKS: assert property (
    core_ok && ent_go_i && !ret_go_i && ent_kind_i == ENT_TRAP2
    |=> cc_q[6] == $past(cc_q[6]) && cc_q[4] == $past(cc_q[4]) && cc_q[7])
    else $error("trap two touched masks");
  AST_NORM_ENTRY: assert property (
    core_ok && ent_go_i && !ret_go_i && ent_kind_i == ENT_NORM
    |=> cc_q[`CC_NMASK] && cc_q[`CC_FMASK] == $past(cc_q[`CC_FMASK]))
    else $error("normal entry masks wrong");
  AST_RET_EXTENT: assert property (
    core_ok && ret_go_i |=> ret_entire_o == $past(ret_cc_i[7]))
    else $error("return extent wrong");

  COV_PUSH_PULL: cover property (
    stk_go_i && stk_push_i ##1 stk_go_i && !stk_push_i);
  COV_OVERFLOW: cover property (
    alu_go_i ##1 cc_q[`CC_OVFL]);
  COV_FAST_RET: cover property (
    ent_go_i && ent_kind_i == ENT_FAST ##[1:20] ret_go_i);
endmodule

//--- tb.sv
// Self-checking testbench of the program register file
`timescale 1ns/1ns
`include "cpu_regs_params.svh"

module tb;
  import cpu_regs_pkg::*;

  typedef struct {
    alu_kind_t kind;
    logic wide;
    logic low;
    logic [15:0] acc;
    logic [15:0] opnd;
    logic [7:0] cc;
    logic [15:0] acc_exp;
    logic [7:0] cc_exp;
  } row_t;

  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic alu_go_i = 1'b0;
  alu_kind_t alu_kind_i = ALU_LD;
  logic alu_wide_i = 1'b0;
  logic alu_dst_low_i = 1'b0;
  logic [15:0] alu_opnd_i = 16'h0;
  logic dir_go_i = 1'b0;
  logic [7:0] dir_low_i = 8'h0;
  logic idx_go_i = 1'b0;
  base_sel_t idx_base_i = BASE_IDX1;
  logic [15:0] idx_ofs_i = 16'h0;
  logic [2:0] idx_step_i = 3'h0;
  logic stk_go_i = 1'b0;
  logic stk_user_i = 1'b0;
  logic stk_push_i = 1'b0;
  logic ent_go_i = 1'b0;
  entry_kind_t ent_kind_i = ENT_NMI;
  logic ret_go_i = 1'b0;
  logic [7:0] ret_cc_i = 8'h0;
  logic pc_load_i = 1'b0;
  logic [15:0] pc_value_i = 16'h0;
  logic pc_inc_i = 1'b0;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  logic [15:0] addr_o;
  logic [15:0] acc_pair_o;
  logic [15:0] prog_counter_o;
  logic [7:0] cond_codes_o;
  logic ret_entire_o;
  int n_errors = 0;
  int check_count = 0;
  row_t rows[10];
  base_sel_t bsel[4] = '{BASE_IDX1, BASE_IDX2, BASE_USP, BASE_HSP};
  logic [7:0] bofs[4] = '{`RF_OFS_IDX1, `RF_OFS_IDX2, `RF_OFS_USP,
    `RF_OFS_HSP};
  entry_kind_t ekind[7] = '{ENT_NMI, ENT_FAST, ENT_NORM, ENT_RESET,
    ENT_TRAP1, ENT_TRAP2, ENT_TRAP3};
  logic [7:0] ecc[7] = '{8'hD0, 8'h50, 8'h90, 8'hD0, 8'hD0, 8'h80, 8'h80};

  // The one slave's ready closes the loop as the bus's ready
  cpu_program_registers cpu_program_registers_inst (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(1'b1),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .alu_go_i(alu_go_i), .alu_kind_i(alu_kind_i),
    .alu_wide_i(alu_wide_i), .alu_dst_low_i(alu_dst_low_i),
    .alu_opnd_i(alu_opnd_i), .dir_go_i(dir_go_i), .dir_low_i(dir_low_i),
    .idx_go_i(idx_go_i), .idx_base_i(idx_base_i), .idx_ofs_i(idx_ofs_i),
    .idx_step_i(idx_step_i), .stk_go_i(stk_go_i), .stk_user_i(stk_user_i),
    .stk_push_i(stk_push_i), .ent_go_i(ent_go_i), .ent_kind_i(ent_kind_i),
    .ret_go_i(ret_go_i), .ret_cc_i(ret_cc_i), .pc_load_i(pc_load_i),
    .pc_value_i(pc_value_i), .pc_inc_i(pc_inc_i), .addr_o(addr_o),
    .acc_pair_o(acc_pair_o), .prog_counter_o(prog_counter_o),
    .cond_codes_o(cond_codes_o), .ret_entire_o(ret_entire_o)
  );

  always #5 clk_sys_i = ~clk_sys_i;

  // ==========================================
  // Reporting
  task automatic final_report;
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // ==========================================
  // Bus master
  task automatic wait_ready;
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk_sys_i);
      if (hreadyout_o === 1'b1)
        return;
    end
    n_errors++;
    final_report();
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    haddr_i <= {24'h0, a};
    wait_ready();
    htrans_i <= 2'h0;
    hsel_i <= 1'b0;
    hwdata_i <= wd;
    wait_ready();
    rd = hrdata_o;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(x, exp);
  endtask

  // ==========================================
  // Core strobes: one cycle high, result seen after the taking edge
  task automatic pulse;
    @(posedge clk_sys_i);
    alu_go_i <= 1'b0;
    dir_go_i <= 1'b0;
    idx_go_i <= 1'b0;
    stk_go_i <= 1'b0;
    ent_go_i <= 1'b0;
    ret_go_i <= 1'b0;
    pc_load_i <= 1'b0;
    pc_inc_i <= 1'b0;
    #1;
  endtask

  task automatic idx(input base_sel_t b, input logic [15:0] o,
                     input logic [2:0] s);
    @(posedge clk_sys_i);
    idx_go_i <= 1'b1;
    idx_base_i <= b;
    idx_ofs_i <= o;
    idx_step_i <= s;
    pulse();
  endtask

  task automatic stk(input logic user, input logic push);
    @(posedge clk_sys_i);
    stk_go_i <= 1'b1;
    stk_user_i <= user;
    stk_push_i <= push;
    pulse();
  endtask

  task automatic ret(input logic [7:0] c);
    @(posedge clk_sys_i);
    ret_go_i <= 1'b1;
    ret_cc_i <= c;
    pulse();
  endtask

  task automatic do_reset;
    @(posedge clk_sys_i);
    rstn_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    #1;
  endtask

  initial
  begin
    rows[0] = '{ALU_ADD, 1'b0, 1'b0, 16'h7F00, 16'h0001, 8'h00,
      16'h8000, 8'h2A};
    rows[1] = '{ALU_ADC, 1'b0, 1'b1, 16'h00FF, 16'h0001, 8'h01,
      16'h0001, 8'h21};
    rows[2] = '{ALU_SUB, 1'b0, 1'b0, 16'h0000, 16'h0001, 8'h00,
      16'hFF00, 8'h09};
    rows[3] = '{ALU_SBC, 1'b0, 1'b1, 16'h0080, 16'h0000, 8'h01,
      16'h007F, 8'h02};
    rows[4] = '{ALU_CMP, 1'b0, 1'b0, 16'h0500, 16'h0005, 8'h00,
      16'h0500, 8'h04};
    rows[5] = '{ALU_NEG, 1'b0, 1'b1, 16'h0001, 16'h0000, 8'h00,
      16'h00FF, 8'h09};
    rows[6] = '{ALU_LD, 1'b1, 1'b0, 16'h1234, 16'h8000, 8'h03,
      16'h8000, 8'h09};
    rows[7] = '{ALU_ADD, 1'b1, 1'b0, 16'h00FF, 16'h0001, 8'h20,
      16'h0100, 8'h20};
    rows[8] = '{ALU_ADD, 1'b0, 1'b0, 16'h8000, 16'h0080, 8'h00,
      16'h0000, 8'h07};
    // Byte load into the high accumulator: flags from the loaded byte
    rows[9] = '{ALU_LD, 1'b0, 1'b0, 16'h1234, 16'h0080, 8'h06,
      16'h8034, 8'h08};
    repeat (3) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    #1;
    check(cond_codes_o, 8'h50);
    rdchk(`RF_OFS_PAGE, 32'h0);
    // Table of accumulator operations
    for (int k = 0; k < 10; k++)
    begin
      wr(`RF_OFS_ACC, {16'h0, rows[k].acc});
      wr(`RF_OFS_CC, {24'h0, rows[k].cc});
      @(posedge clk_sys_i);
      alu_go_i <= 1'b1;
      alu_kind_i <= rows[k].kind;
      alu_wide_i <= rows[k].wide;
      alu_dst_low_i <= rows[k].low;
      alu_opnd_i <= rows[k].opnd;
      pulse();
      check(acc_pair_o, rows[k].acc_exp);
      check(cond_codes_o, rows[k].cc_exp);
    end
    // Direct page supplies the upper address byte
    wr(`RF_OFS_PAGE, 32'h12);
    @(posedge clk_sys_i);
    dir_go_i <= 1'b1;
    dir_low_i <= 8'h34;
    pulse();
    check(addr_o, 16'h1234);
    // Every pointer serves as an indexed base
    for (int j = 0; j < 4; j++)
    begin
      wr(bofs[j], 32'h1000 + 32'h100 * j);
      idx(bsel[j], 16'h0005, 3'h0);
      check(addr_o, 16'h1005 + 16'h0100 * j);
    end
    idx(BASE_IDX1, 16'h0005, 3'h6);
    check(addr_o, 16'h1003);
    rdchk(`RF_OFS_IDX1, 32'h0FFE);
    idx(BASE_IDX1, 16'h0000, 3'h1);
    check(addr_o, 16'h0FFE);
    rdchk(`RF_OFS_IDX1, 32'h0FFF);
    // Stack pointers address the last byte pushed
    stk(1'b0, 1'b1);
    check(addr_o, 16'h12FF);
    rdchk(`RF_OFS_HSP, 32'h12FF);
    stk(1'b0, 1'b0);
    check(addr_o, 16'h12FF);
    rdchk(`RF_OFS_HSP, 32'h1300);
    stk(1'b1, 1'b1);
    check(addr_o, 16'h11FF);
    rdchk(`RF_OFS_USP, 32'h11FF);
    rdchk(`RF_OFS_HSP, 32'h1300);
    // Program counter load, advance and relative base
    @(posedge clk_sys_i);
    pc_load_i <= 1'b1;
    pc_value_i <= 16'h2000;
    pulse();
    check(prog_counter_o, 16'h2000);
    @(posedge clk_sys_i);
    pc_inc_i <= 1'b1;
    pulse();
    rdchk(`RF_OFS_PC, 32'h2001);
    idx(BASE_PC, 16'h0010, 3'h0);
    check(addr_o, 16'h2011);
    // Every exception kind against the two masks and entire flag
    for (int e = 0; e < 7; e++)
    begin
      wr(`RF_OFS_CC, 32'h0);
      @(posedge clk_sys_i);
      ent_go_i <= 1'b1;
      ent_kind_i <= ekind[e];
      pulse();
      check(cond_codes_o, ecc[e]);
    end
    ret(8'h80);
    check(ret_entire_o, 1'b1);
    check(cond_codes_o, 8'h80);
    ret(8'h05);
    check(ret_entire_o, 1'b0);
    // Unmapped place reads zero with an OKAY response
    rdchk(8'h20, 32'h0);
    check(hresp_o, 1'b0);
    // Reset in mid-run clears the page base again
    wr(`RF_OFS_PAGE, 32'hA5);
    rdchk(`RF_OFS_PAGE, 32'hA5);
    do_reset();
    check(cond_codes_o, 8'h50);
    rdchk(`RF_OFS_PAGE, 32'h0);
    final_report();
  end
endmodule
